/* rtl/gdr_defs.vh */
`ifndef GDR_DEFS_VH
`define GDR_DEFS_VH
// Register indices; each register takes one word, so its byte address is four times its index.
`define GDR_IDX_GENERAL_STATUS 8'h50
`define GDR_IDX_DELAY_STATUS 8'h51
`define GDR_ADDR_GENERAL_STATUS 10'h140
`define GDR_ADDR_DELAY_STATUS 10'h144
`define GDR_ADDR_CTRL 10'h200
// Field positions of the delay regulation status register.
`define GDR_BIT_HB1_REG 0
`define GDR_BIT_HB2_REG 1
`define GDR_BIT_HB1_CHG 4
`define GDR_BIT_HB2_CHG 5
`define GDR_BIT_HB1_DCHG 8
`define GDR_BIT_HB2_DCHG 9
// Field positions of the general status register.
`define GDR_BIT_PWM_LEVEL 0
`define GDR_BIT_HB1_VOUT 6
`define GDR_BIT_HB2_VOUT 7
// Reset value and restart keep mask.
`define GDR_RESET_VALUE 16'h0000
`define GDR_RESTART_KEEP 16'h00C1
// Control register fields.
`define GDR_BIT_SOFT_RESET 0
`define GDR_BIT_RESTART 1
`endif

/* rtl/gdr_sync.v */
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin levels.
module gdr_sync #(
  parameter WIDTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // The first stage is read by the second stage only.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // gdr_sync

/* rtl/gdr_status.v */
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "gdr_defs.vh"
module gdr_status (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire bridge1_on_delay_regulated,
  input wire bridge1_off_delay_regulated,
  input wire bridge2_on_delay_regulated,
  input wire bridge2_off_delay_regulated,
  input wire bridge1_charge_at_limit,
  input wire bridge2_charge_at_limit,
  input wire bridge1_discharge_at_limit,
  input wire bridge2_discharge_at_limit,
  input wire [1:0] adaptive_gate_control_code,
  input wire bridge1_pwm_enable,
  input wire bridge2_pwm_enable,
  input wire bridge1_high_impedance,
  input wire bridge2_high_impedance,
  input wire pwm_input_level,
  input wire bridge1_output_high,
  input wire bridge2_output_high
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  // Number of level input bits that cross into the bus clock domain.
  localparam NPIN = 17;
  // Number of half-bridges whose status is reported.
  localparam NBRIDGE = 2;
  wire [NPIN-1:0] pins_raw;
  wire [NPIN-1:0] pins;

  // All sources are analogue-side levels, so every one of them is retimed here.
  assign pins_raw = {bridge2_output_high, bridge1_output_high, pwm_input_level,
                     bridge2_high_impedance, bridge1_high_impedance,
                     bridge2_pwm_enable, bridge1_pwm_enable, adaptive_gate_control_code,
                     bridge2_discharge_at_limit, bridge1_discharge_at_limit,
                     bridge2_charge_at_limit, bridge1_charge_at_limit,
                     bridge2_off_delay_regulated, bridge2_on_delay_regulated,
                     bridge1_off_delay_regulated, bridge1_on_delay_regulated};

  // Bits settle one by one, so a read may mix levels from two neighbouring cycles.
  gdr_sync #(.WIDTH(NPIN)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // ****************************************
  // Synchronised pin fields
  // ****************************************
  // Per-bridge sources are gathered into vectors indexed by bridge number.
  wire [NBRIDGE-1:0] on_delay_regulated;
  wire [NBRIDGE-1:0] off_delay_regulated;
  wire [NBRIDGE-1:0] charge_at_limit;
  wire [NBRIDGE-1:0] discharge_at_limit;
  wire [NBRIDGE-1:0] pwm_enabled;
  wire [NBRIDGE-1:0] high_impedance;
  wire [NBRIDGE-1:0] output_high;
  wire [1:0] gate_code;
  wire gate_code_active;
  wire pwm_level;

  // Field slices follow the packing order of the synchroniser input above.
  assign on_delay_regulated = {pins[2], pins[0]};
  assign off_delay_regulated = {pins[3], pins[1]};
  assign charge_at_limit = pins[5:4];
  assign discharge_at_limit = pins[7:6];
  assign gate_code = pins[9:8];
  assign pwm_enabled = pins[11:10];
  assign high_impedance = pins[13:12];
  assign pwm_level = pins[14];
  assign output_high = pins[16:15];
  // Codes 10 and 11 select adaptive control; codes 00 and 01 leave the currents fixed.
  assign gate_code_active = gate_code[1];

  // ****************************************
  // Per-bridge flags
  // ****************************************
  wire [NBRIDGE-1:0] regulated;
  wire [NBRIDGE-1:0] live;
  wire [NBRIDGE-1:0] charge_flag;
  wire [NBRIDGE-1:0] discharge_flag;

  // Both bridges share one decode, so a fix to one cannot miss the other.
  genvar gi;
  generate
    for (gi = 0; gi < NBRIDGE; gi = gi + 1) begin : g_bridge
      // Either delay in regulation is enough to raise the bridge flag.
      assign regulated[gi] = on_delay_regulated[gi] | off_delay_regulated[gi];
      // PWM off, a floating bridge or a fixed gate code forces the no-clamp reading.
      assign live[gi] = gate_code_active & pwm_enabled[gi] & ~high_impedance[gi];
      // Clamp flags are active low: zero means the current sits at a limit.
      assign charge_flag[gi] = ~(live[gi] & charge_at_limit[gi]);
      assign discharge_flag[gi] = ~(live[gi] & discharge_at_limit[gi]);
    end
  endgenerate

  // ****************************************
  // Live status assembly
  // ****************************************
  reg [15:0] next_delay_status;
  reg [15:0] next_general_status;

  // Every unnamed bit stays zero, so reserved positions read zero.
  always @* begin
    next_delay_status = 16'h0000;
    next_delay_status[`GDR_BIT_HB1_REG] = regulated[0];
    next_delay_status[`GDR_BIT_HB2_REG] = regulated[1];
    next_delay_status[`GDR_BIT_HB1_CHG] = charge_flag[0];
    next_delay_status[`GDR_BIT_HB2_CHG] = charge_flag[1];
    next_delay_status[`GDR_BIT_HB1_DCHG] = discharge_flag[0];
    next_delay_status[`GDR_BIT_HB2_DCHG] = discharge_flag[1];
    next_general_status = 16'h0000;
    next_general_status[`GDR_BIT_PWM_LEVEL] = pwm_level;
    next_general_status[`GDR_BIT_HB1_VOUT] = output_high[0];
    next_general_status[`GDR_BIT_HB2_VOUT] = output_high[1];
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  reg dphase;
  reg dwrite;
  reg [9:0] daddr;
  reg soft_reset;
  reg restart;
  reg [15:0] delay_status;
  reg [15:0] general_status;
  // Only non-sequential and sequential transfers carry a request; idle and busy are ignored.
  wire take = hsel & hready & htrans[1];
  // A control write is recognised in its data phase, while the write data stand.
  wire ctrl_write = dphase & dwrite & (daddr == `GDR_ADDR_CTRL);
  // Bits that survive a restart.
  wire [15:0] keep = `GDR_RESTART_KEEP;

  // Address phase is captured; the slave never inserts wait states.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= 1'b0;
      dwrite <= 1'b0;
      daddr <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dphase <= take;
      dwrite <= take & hwrite;
      if (take) begin
        daddr <= haddr[9:0];
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Control strobes
  // ****************************************
  // Control writes are one-cycle strobes; status registers take no writes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_reset <= 1'b0;
      restart <= 1'b0;
    end else begin
      soft_reset <= ctrl_write & hwdata[`GDR_BIT_SOFT_RESET];
      restart <= ctrl_write & hwdata[`GDR_BIT_RESTART];
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  // Status snapshots follow the live pins; reset and restart override for one cycle.
  // The cleared value lasts one cycle only, because the live sources refill it at once.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_status <= `GDR_RESET_VALUE;
      general_status <= `GDR_RESET_VALUE;
    end else if (soft_reset) begin
      delay_status <= `GDR_RESET_VALUE;
      general_status <= `GDR_RESET_VALUE;
    end else if (restart) begin
      delay_status <= delay_status & keep;
      general_status <= general_status & keep;
    end else begin
      delay_status <= next_delay_status;
      general_status <= next_general_status;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read data is registered at the address phase; reads change nothing else.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      case (haddr[9:0])
        `GDR_ADDR_DELAY_STATUS: hrdata <= {16'h0000, delay_status};
        `GDR_ADDR_GENERAL_STATUS: hrdata <= {16'h0000, general_status};
        default: hrdata <= 32'h00000000;
      endcase
    end else begin
      hrdata <= 32'h00000000;
    end
  end
endmodule // gdr_status

/* tb/gdr_status_chk.sv */
`timescale 1ns/1ps
// ****
// Bus and status checker
// ****
module gdr_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire bridge1_on_delay_regulated,
  input wire bridge1_off_delay_regulated,
  input wire bridge2_on_delay_regulated,
  input wire bridge2_off_delay_regulated,
  input wire bridge1_charge_at_limit,
  input wire bridge2_charge_at_limit,
  input wire bridge2_discharge_at_limit,
  input wire [1:0] adaptive_gate_control_code,
  input wire bridge1_pwm_enable,
  input wire bridge2_pwm_enable,
  input wire bridge1_high_impedance,
  input wire bridge2_high_impedance
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Decoded transfers and the expected live flag levels.
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire wr = hsel && hready && htrans[1] && hwrite;
  wire tdr = rd && haddr[9:0] == 10'h144;
  wire reg1 = bridge1_on_delay_regulated | bridge1_off_delay_regulated;
  wire on1 = adaptive_gate_control_code[1] && bridge1_pwm_enable && !bridge1_high_impedance;
  wire on2 = adaptive_gate_control_code[1] && bridge2_pwm_enable && !bridge2_high_impedance;
  wire reg2 = bridge2_on_delay_regulated | bridge2_off_delay_regulated;
  wire cl4 = !(on1 && bridge1_charge_at_limit);
  wire cl5 = !(on2 && bridge2_charge_at_limit);
  wire cl9 = !(on2 && bridge2_discharge_at_limit);
  // Pins pass two sync flops and a register, so only a rested pin is compared.
  sequence s_calm(x);
    ($stable(x) && !wr)[*5] ##0 tdr;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_reserved_zero: assert property (
    tdr |=> (hrdata & 32'hFFFFFCCC) == 32'h0) else $error("reserved bit set");
  a_hb1_regulated: assert property (
    s_calm(reg1) |=> hrdata[0] == $past(reg1)) else $error("regulation flag wrong");
  a_hb1_charge: assert property (
    s_calm(cl4) |=> hrdata[4] == $past(cl4)) else $error("charge flag wrong");
  a_hb2_regulated: assert property (
    s_calm(reg2) |=> hrdata[1] == $past(reg2)) else $error("regulation flag two wrong");
  a_hb2_charge: assert property (
    s_calm(cl5) |=> hrdata[5] == $past(cl5)) else $error("charge flag two wrong");
  a_hb2_discharge: assert property (
    s_calm(cl9) |=> hrdata[9] == $past(cl9)) else $error("discharge flag wrong");
  a_idle_zero: assert property (!rd |=> hrdata == 32'h0) else $error("data outside read");
  a_unmapped_zero: assert property (rd && haddr[9:0] != 10'h140 && haddr[9:0] != 10'h144
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
endmodule // gdr_chk
bind gdr_status gdr_chk chk_i (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .bridge1_on_delay_regulated(bridge1_on_delay_regulated),
  .bridge1_off_delay_regulated(bridge1_off_delay_regulated),
  .bridge2_on_delay_regulated(bridge2_on_delay_regulated),
  .bridge2_off_delay_regulated(bridge2_off_delay_regulated),
  .bridge1_charge_at_limit(bridge1_charge_at_limit),
  .bridge2_charge_at_limit(bridge2_charge_at_limit),
  .bridge2_discharge_at_limit(bridge2_discharge_at_limit),
  .adaptive_gate_control_code(adaptive_gate_control_code),
  .bridge1_pwm_enable(bridge1_pwm_enable),
  .bridge2_pwm_enable(bridge2_pwm_enable),
  .bridge1_high_impedance(bridge1_high_impedance),
  .bridge2_high_impedance(bridge2_high_impedance)
);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [16:0] p = 17'h0;
  int fail_count = 0, checks = 0, cyc = 0;
  wire hready = hreadyout;
  // Each row holds the pin vector and the status word it must give.
  logic [32:0] rows [8] = '{33'h000000330, 33'h000010331, 33'h000080332, 33'h00EF00000,
    33'h01FF20111, 33'h00DF00330, 33'h006F00220, 33'h00F000330};
  gdr_status uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .bridge1_on_delay_regulated(p[0]), .bridge1_off_delay_regulated(p[1]),
    .bridge2_on_delay_regulated(p[2]), .bridge2_off_delay_regulated(p[3]),
    .bridge1_charge_at_limit(p[4]), .bridge2_charge_at_limit(p[5]),
    .bridge1_discharge_at_limit(p[6]), .bridge2_discharge_at_limit(p[7]),
    .adaptive_gate_control_code(p[9:8]), .bridge1_pwm_enable(p[10]),
    .bridge2_pwm_enable(p[11]), .bridge1_high_impedance(p[12]),
    .bridge2_high_impedance(p[13]), .pwm_input_level(p[14]),
    .bridge1_output_high(p[15]), .bridge2_output_high(p[16]));
  initial forever #10 hclk = ~hclk;
  // The master holds each phase until hready is seen, as a slow slave may stall.
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // A control strobe lasts one cycle, so the read waits one edge after the write.
  task automatic strobe(input logic [31:0] d, a, e);
    xfer(1'b1, 32'h200, d, r);
    @(posedge hclk);
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      p <= rows[i][32:16];
      repeat (6) @(posedge hclk);
      xfer(1'b0, 32'h144, 32'h0, r);
      chk(r, {16'h0, rows[i][15:0]});
    end
    p <= 17'h1C000;
    repeat (6) @(posedge hclk);
    xfer(1'b0, 32'h140, 32'h0, r);
    chk(r, 32'hC1);
    xfer(1'b1, 32'h144, 32'hFFFF, r);
    xfer(1'b0, 32'h144, 32'h0, r);
    chk(r, 32'h330);
    xfer(1'b0, 32'h3FC, 32'h0, r);
    chk(r, 32'h0);
    xfer(1'b0, 32'h200, 32'h0, r);
    chk(r, 32'h0);
    p <= 17'h1C001;
    repeat (6) @(posedge hclk);
    strobe(32'h1, 32'h144, 32'h0);
    strobe(32'h1, 32'h140, 32'h0);
    strobe(32'h2, 32'h144, 32'h1);
    strobe(32'h2, 32'h140, 32'hC1);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h144, 32'h0, r);
    chk(r, 32'h0);
    repeat (4) @(posedge hclk);
    xfer(1'b0, 32'h144, 32'h0, r);
    chk(r, 32'h331);
    wrap_up;
  end
endmodule // tb_top
